//--- hdl/port1_gpio_cfg.svh
// constants for general-purpose port 1: offsets, reset values, field layout
// assumes inclusion by the port module and its bench only
`ifndef PORT1_GPIO_CFG_SVH
`define PORT1_GPIO_CFG_SVH

// register indices; every register is one aligned word, so byte address = 4 * index
`define P1_IDX_DATA      16'hFFD4
`define P1_IDX_DIRECTION 16'hFFE4
`define P1_IDX_PULLUP    16'hFFED
`define P1_IDX_FUNCSEL   16'hFFFC
// reset values
`define P1_RST_DATA      8'h00
`define P1_RST_DIRECTION 8'h00
`define P1_RST_PULLUP    8'h00
`define P1_RST_FUNCSEL   8'h04
// implemented pin bits 7..4 and 0
`define P1_PIN_MASK      8'hF1
// function-select bits fixed at one
`define P1_FUNCSEL_ONES  8'h04
// direction register read value
`define P1_DIR_READ      8'hFF
// bus answers
`define P1_RESP_OKAY     2'h0
`define P1_RESP_SLVERR   2'h2

`endif

//--- hdl/port1_gpio_pkg.sv
// types shared by the port 1 design
// assumes nothing beyond the constants header
package port1_gpio_pkg;
  typedef logic [7:0] byte_type;
  typedef enum logic [2:0] {
    REG_DATA, REG_DIR, REG_PULLUP, REG_FUNCSEL, REG_NONE
  } reg_sel_type;
endpackage

//--- hdl/port1_general_io.sv
// general-purpose port 1: five pins, AXI4-Lite register slave
// assumes pins synchronous-capable, single 10 MHz clock, sync reset
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "port1_gpio_cfg.svh"

// Summary of operation
// - five pins at bits 7..4 and 0
// - output pin reads stored data bit
// - input pin reads sampled pin level
// - data bits 3..1 read zero, ignore writes
// - data register resets to zero
// - direction 1 drives data, 0 releases pin
// - direction and data only act on the pins in GPIO mode
// - direction register write-only, reads all ones
// - direction resets to zero, all inputs
// - pull-up register at FFED, RW, resets zero
// - function select at FFFC, RW, resets 04
// - input pin pull-up follows pull-up bit in GPIO mode only
// - select bits route pins to alternate functions
// - select bit 2 reads one, 3 and 1 zero
// - alternate function overrides direction bit
module port1_general_io
  import port1_gpio_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // axi4-lite write address and data
  input  wire logic [17:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [17:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // port pins, four signals each
  input  wire logic [7:0]  pinIn,
  output logic [7:0]       pinOut,
  output logic [7:0]       pinOe,
  output logic [7:0]       pullupEnable,
  // alternate functions
  input  wire logic        pwmOutput,
  input  wire logic        clockDividerOutput,
  output logic             extInterruptLine3,
  output logic             timerTriggerInput,
  output logic             extInterruptLine2,
  output logic             extInterruptLine1
);

  // address decode shared by read and write paths
  function automatic reg_sel_type decode(input logic [15:0] a);
    unique case (a)
      `P1_IDX_DATA:      decode = REG_DATA;
      `P1_IDX_DIRECTION: decode = REG_DIR;
      `P1_IDX_PULLUP:    decode = REG_PULLUP;
      `P1_IDX_FUNCSEL:   decode = REG_FUNCSEL;
      default:           decode = REG_NONE;
    endcase
  endfunction

  byte_type    portData, next_portData;
  byte_type    portDir, next_portDir;
  byte_type    pullupCtrl, next_pullupCtrl;
  byte_type    funcSel, next_funcSel;
  logic        awHeld, next_awHeld;
  logic        wHeld, next_wHeld;
  logic [17:0] awAddr, next_awAddr;
  logic [31:0] wData, next_wData;
  logic [3:0]  wStrb, next_wStrb;
  logic        bValid, next_bValid;
  logic [1:0]  bResp, next_bResp;
  logic        rValid, next_rValid;
  logic [31:0] rData, next_rData;
  logic [1:0]  rResp, next_rResp;
  byte_type    syncA, syncB;
  byte_type    readPort, wByte;
  logic        wLane;
  reg_sel_type wSel, rSel;

  // pin synchroniser; first stage feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      syncA <= 8'h00;
      syncB <= 8'h00;
    end else begin
      syncA <= pinIn;
      syncB <= syncA;
    end
  end

  // port read: stored data for outputs, pin level for inputs
  assign readPort = ((portDir & portData) | (~portDir & syncB))
                    & `P1_PIN_MASK;

  // decode: each register is one aligned word, its index in bits 17..2
  assign wSel  = decode(awAddr[17:2]);
  assign wByte = wData[7:0];
  assign wLane = wStrb[0];
  assign rSel  = decode(s_axi_araddr[17:2]);

  // bus handshakes and register updates; write fires once both halves held
  always_comb begin
    next_awHeld     = awHeld;
    next_wHeld      = wHeld;
    next_awAddr     = awAddr;
    next_wData      = wData;
    next_wStrb      = wStrb;
    next_bValid     = bValid;
    next_bResp      = bResp;
    next_rValid     = rValid;
    next_rData      = rData;
    next_rResp      = rResp;
    next_portData   = portData;
    next_portDir    = portDir;
    next_pullupCtrl = pullupCtrl;
    next_funcSel    = funcSel;
    // take only while ready shows, so the cycle after reset takes nothing
    if (s_axi_awvalid && s_axi_awready) begin
      next_awHeld = 1'b1;
      next_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_wHeld = 1'b1;
      next_wData = s_axi_wdata;
      next_wStrb = s_axi_wstrb;
    end
    if (awHeld && wHeld && !bValid) begin
      next_awHeld = 1'b0;
      next_wHeld  = 1'b0;
      next_bValid = 1'b1;
      next_bResp  = (wSel == REG_NONE) ? `P1_RESP_SLVERR : `P1_RESP_OKAY;
      if (wLane) begin
        unique case (wSel)
          REG_DATA:    next_portData = wByte & `P1_PIN_MASK;
          REG_DIR:     next_portDir = wByte & `P1_PIN_MASK;
          REG_PULLUP:  next_pullupCtrl = wByte & `P1_PIN_MASK;
          REG_FUNCSEL: next_funcSel = (wByte & `P1_PIN_MASK)
                                      | `P1_FUNCSEL_ONES;
          REG_NONE:    next_funcSel = funcSel;
        endcase
      end
    end
    if (bValid && s_axi_bready)
      next_bValid = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rValid = 1'b1;
      next_rResp  = (rSel == REG_NONE) ? `P1_RESP_SLVERR : `P1_RESP_OKAY;
      next_rData  = 32'h0000_0000;
      unique case (rSel)
        REG_DATA:    next_rData[7:0] = readPort;
        REG_DIR:     next_rData[7:0] = `P1_DIR_READ;
        REG_PULLUP:  next_rData[7:0] = pullupCtrl;
        REG_FUNCSEL: next_rData[7:0] = funcSel;
        REG_NONE:    next_rData = 32'h0000_0000;
      endcase // direction reads all ones
    end else if (rValid && s_axi_rready) begin
      next_rValid = 1'b0;
    end
  end

  // register state; reset values
  always_ff @(posedge clk) begin
    if (rst) begin
      awHeld     <= 1'b0;
      wHeld      <= 1'b0;
      awAddr     <= 18'h0_0000;
      wData      <= 32'h0000_0000;
      wStrb      <= 4'h0;
      bValid     <= 1'b0;
      bResp      <= `P1_RESP_OKAY;
      rValid     <= 1'b0;
      rData      <= 32'h0000_0000;
      rResp      <= `P1_RESP_OKAY;
      portData   <= `P1_RST_DATA;
      portDir    <= `P1_RST_DIRECTION;
      pullupCtrl <= `P1_RST_PULLUP;
      funcSel    <= `P1_RST_FUNCSEL;
    end else begin
      awHeld     <= next_awHeld;
      wHeld      <= next_wHeld;
      awAddr     <= next_awAddr;
      wData      <= next_wData;
      wStrb      <= next_wStrb;
      bValid     <= next_bValid;
      bResp      <= next_bResp;
      rValid     <= next_rValid;
      rData      <= next_rData;
      rResp      <= next_rResp;
      portData   <= next_portData;
      portDir    <= next_portDir;
      pullupCtrl <= next_pullupCtrl;
      funcSel    <= next_funcSel;
    end
  end

  // ready is high whenever the holding slot is free, except in reset and the first cycle after it
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_awready <= !next_awHeld;
      s_axi_wready  <= !next_wHeld;
      s_axi_arready <= !next_rValid;
    end
  end
  assign s_axi_bvalid = bValid;
  assign s_axi_bresp  = bResp;
  assign s_axi_rvalid = rValid;
  assign s_axi_rdata  = rData;
  assign s_axi_rresp  = rResp;

  // pin drive computed one stage ahead so outputs leave flip-flops
  byte_type next_out, next_oe, next_pu;
  always_comb begin
    next_out = next_portData;
    next_oe  = next_portDir & ~next_funcSel & `P1_PIN_MASK;
    next_pu  = ~next_portDir & ~next_funcSel & next_pullupCtrl
               & `P1_PIN_MASK;
    // alternate outputs drive regardless of direction
    if (next_funcSel[4]) begin
      next_out[4] = pwmOutput;
      next_oe[4]  = 1'b1;
    end
    if (next_funcSel[0]) begin
      next_out[0] = clockDividerOutput;
      next_oe[0]  = 1'b1;
    end
  end

  // pin and alternate-input registers; bits 3..1 never driven
  always_ff @(posedge clk) begin
    if (rst) begin
      pinOut            <= 8'h00;
      pinOe             <= 8'h00;
      pullupEnable      <= 8'h00;
      extInterruptLine3 <= 1'b0;
      timerTriggerInput <= 1'b0;
      extInterruptLine2 <= 1'b0;
      extInterruptLine1 <= 1'b0;
    end else begin
      pinOut            <= next_out & `P1_PIN_MASK;
      pinOe             <= next_oe;
      pullupEnable      <= next_pu;
      extInterruptLine3 <= funcSel[7] & syncB[7];
      timerTriggerInput <= funcSel[7] & syncB[7];
      extInterruptLine2 <= funcSel[6] & syncB[6];
      extInterruptLine1 <= funcSel[5] & syncB[5];
    end
  end

  // assertions
  resv_zero_a: assert property (@(posedge clk) disable iff (rst)
    (portData & ~`P1_PIN_MASK) == 8'h00)
    else $error("data reserved bits set");
  dir_read_a: assert property (@(posedge clk) disable iff (rst)
    s_axi_arvalid && s_axi_arready && rSel == REG_DIR |=>
    rData[7:0] == 8'hFF)
    else $error("direction read not all ones");
  sel_bit2_a: assert property (@(posedge clk) disable iff (rst)
    funcSel[2] && !funcSel[3] && !funcSel[1])
    else $error("function select reserved bits wrong");
  // pin flops load from the same next values as the registers beside them
  oe_gpio_a: assert property (@(posedge clk) disable iff (rst)
    pinOe[6] == (portDir[6] && !funcSel[6]))
    else $error("output enable wrong");
  alt_pwm_a: assert property (@(posedge clk) disable iff (rst)
    funcSel[4] |-> pinOe[4])
    else $error("pwm pin not driven");
  out_data_a: assert property (@(posedge clk) disable iff (rst)
    portDir[5] && !funcSel[5] |->
    pinOut[5] == portData[5] && readPort[5] == portData[5])
    else $error("output pin data wrong");
  in_read_a: assert property (@(posedge clk) disable iff (rst)
    !portDir[7] |-> readPort[7] == syncB[7])
    else $error("input read wrong");
  pull_in_a: assert property (@(posedge clk) disable iff (rst)
    ##1 pullupEnable[0] |-> !pinOe[0])
    else $error("pull-up on driven pin");
  reset_sel_a: assert property (@(posedge clk)
    rst |=> funcSel == 8'h04 && portDir == 8'h00)
    else $error("reset values wrong");
  pin_resv_a: assert property (@(posedge clk) disable iff (rst)
    (pinOe & ~`P1_PIN_MASK) == 8'h00)
    else $error("reserved pin driven");
  write_c: cover property (@(posedge clk) bValid && s_axi_bready);
  strobe_c: cover property (@(posedge clk) awHeld && wHeld && !wLane);
  read_c: cover property (@(posedge clk) rValid && s_axi_rready);
  alt_c: cover property (@(posedge clk) funcSel[7] && syncB[7]);

endmodule // port1_general_io

//--- tb/pin_partner.sv
// pin model for port 1: resolves each wire from all its drivers
// assumes the bench drives extLevel and extEn beside the design
`timescale 1ns/1ps
module pin_partner (
  // clock
  input  wire logic       clk,
  // design side of the pins
  input  wire logic [7:0] pinOut,
  input  wire logic [7:0] pinOe,
  input  wire logic [7:0] pullupEnable,
  // outside drivers
  input  wire logic [7:0] extLevel,
  input  wire logic [7:0] extEn,
  // resolved level
  output logic [7:0]      pinIn
);
  logic [7:0] wobble = 8'h00;

  // a floating pin keeps changing, so a stale value never looks valid
  always_ff @(posedge clk) begin
    wobble <= ~wobble;
  end

  // design drive wins, then outside drive, then pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pinOe[i]) pinIn[i] = pinOut[i];
      else if (extEn[i]) pinIn[i] = extLevel[i];
      else if (pullupEnable[i]) pinIn[i] = 1'b1;
      else pinIn[i] = wobble[i];
    end
  end
endmodule // pin_partner

//--- tb/port1_general_io_tb.sv
// bench for port 1: AXI4-Lite register tasks, pin model on far side
// assumes a 10 MHz clock and a synchronous active-high reset
`timescale 1ns/1ps
`include "port1_gpio_cfg.svh"
module port1_general_io_tb import port1_gpio_pkg::*;;
  localparam logic [1:0] OK = `P1_RESP_OKAY;
  logic        clk = 1'b0, rst = 1'b1;
  logic [17:0] s_axi_awaddr = 18'h0_0000, s_axi_araddr = 18'h0_0000;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  pinIn, pinOut, pinOe, pullupEnable;
  byte_type    extLevel = 8'h63, extEn = 8'hf1;
  logic        pwmOutput = 1'b1, clockDividerOutput = 1'b0;
  logic        extInterruptLine3, timerTriggerInput;
  logic        extInterruptLine2, extInterruptLine1;
  int          fails = 0, check_count = 0, cycles = 0;

  port1_general_io uut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pinIn, .pinOut, .pinOe,
    .pullupEnable, .pwmOutput, .clockDividerOutput, .extInterruptLine3,
    .timerTriggerInput, .extInterruptLine2, .extInterruptLine1);
  pin_partner pins (.clk, .pinOut, .pinOe, .pullupEnable, .extLevel,
    .extEn, .pinIn);

  // free-running clock
  initial forever #50 clk = ~clk;

  // hang guard: the whole sequence needs about a hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    if (fails == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // let pin updates and the synchroniser settle before sampling
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // write: address and data offered together, each dropped when taken
  task automatic wr(input logic [15:0] a, input byte_type d,
                    input logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr <= {a, 2'b00}; // index to aligned byte address
    s_axi_wdata <= {4{d}};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 1'b0;
    chk("bresp", r, s_axi_bresp);
  endtask

  // read: register byte sits in lane 0, upper lanes must be zero
  task automatic rd(input logic [15:0] a, input byte_type e,
                    input logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= {a, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    s_axi_rready <= 1'b0;
    chk($sformatf("rdata %h", a), 32'(e), s_axi_rdata);
    chk("rresp", r, s_axi_rresp);
  endtask

  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    tick(1);
    chk("pinOe", 8'h00, pinOe);
    rd(`P1_IDX_DATA, 8'h61, OK);
    rd(`P1_IDX_DIRECTION, 8'hff, OK);
    rd(`P1_IDX_PULLUP, 8'h00, OK);
    rd(`P1_IDX_FUNCSEL, 8'h04, OK);
    wr(`P1_IDX_DIRECTION, 8'hff, OK);
    rd(`P1_IDX_DATA, 8'h00, OK);
    wr(`P1_IDX_DATA, 8'h5a, OK);
    wr(`P1_IDX_DIRECTION, 8'h90, OK);
    rd(`P1_IDX_DIRECTION, 8'hff, OK);
    tick(4);
    chk("pinOe", 8'h90, pinOe);
    chk("pinOut", 8'h10, pinOut & pinOe);
    chk("extInterruptLine2", 1'b0, extInterruptLine2);
    rd(`P1_IDX_DATA, 8'h71, OK);
    wr(`P1_IDX_PULLUP, 8'hff, OK);
    rd(`P1_IDX_PULLUP, 8'hf1, OK);
    s_axi_wstrb <= 4'h0;
    wr(`P1_IDX_PULLUP, 8'h00, OK);
    s_axi_wstrb <= 4'hf;
    rd(`P1_IDX_PULLUP, 8'hf1, OK);
    tick(1);
    chk("pullupEnable", 8'h61, pullupEnable);
    @(posedge clk);
    extEn <= 8'h00;
    tick(4);
    rd(`P1_IDX_DATA, 8'h71, OK);
    extEn <= 8'hf1;
    wr(`P1_IDX_FUNCSEL, 8'h00, OK);
    rd(`P1_IDX_FUNCSEL, 8'h04, OK);
    wr(`P1_IDX_FUNCSEL, 8'hff, OK);
    rd(`P1_IDX_FUNCSEL, 8'hf5, OK);
    tick(4);
    chk("pinOe", 8'h11, pinOe);
    chk("pullupEnable", 8'h00, pullupEnable);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      pwmOutput <= i[0];
      clockDividerOutput <= ~i[0];
      tick(2);
      chk("pinOut", {3'b000, i[0], 3'b000, ~i[0]}, pinOut & 8'h11);
    end
    chk("extInterruptLine3", 1'b0, extInterruptLine3);
    chk("timerTriggerInput", 1'b0, timerTriggerInput);
    chk("extInterruptLine2", 1'b1, extInterruptLine2);
    chk("extInterruptLine1", 1'b1, extInterruptLine1);
    @(posedge clk);
    extLevel <= 8'h23;
    tick(1);
    chk("extInterruptLine2", 1'b1, extInterruptLine2);
    tick(3);
    chk("extInterruptLine2", 1'b0, extInterruptLine2);
    wr(16'hff00, 8'h55, `P1_RESP_SLVERR);
    rd(16'hff00, 8'h00, `P1_RESP_SLVERR);
    wrap_up();
  end
endmodule // port1_general_io_tb
